// [sim/sid_far_model.sv]
// far side: bus controller and peer card on four-phase links.
// assumes calls of send start just after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module sid_far_model (
	// clock
	input  wire logic        pclk,
	// inbound
	output logic [15:0]      nbc_drive,
	output logic             nbc_in_req,
	input  wire logic        nbc_in_ack,
	output logic [7:0]       peer_in_data,
	output logic             peer_in_req,
	input  wire logic        peer_in_ack,
	// outbound
	input  wire logic        nbc_out_req,
	output logic             nbc_out_ack,
	input  wire logic        peer_out_req,
	output logic             peer_out_ack
);
	int dly_n = 0;
	int dly_p = 0;
	initial begin
		nbc_drive = 16'hA55A;
		peer_in_data = 8'hC3;
		{nbc_in_req, peer_in_req, nbc_out_ack, peer_out_ack} = 4'h0;
	end
	// ====================================
	// sender: data held until ack, then inverted so stale data shows
	task automatic send(input logic peer, input logic [15:0] d);
		int n;
		n = 0;
		if (peer) peer_in_data <= d[7:0];
		else nbc_drive <= d;
		if (peer) peer_in_req <= 1'b1;
		else nbc_in_req <= 1'b1;
		do @(posedge pclk); while (!(peer ? peer_in_ack : nbc_in_ack) && ++n < 60);
		repeat ($urandom % 3) @(posedge pclk);
		if (peer) peer_in_req <= 1'b0;
		else nbc_in_req <= 1'b0;
		if (peer) peer_in_data <= ~d[7:0];
		else nbc_drive <= ~d;
		do @(posedge pclk); while ((peer ? peer_in_ack : nbc_in_ack) && ++n < 120);
	endtask : send
	// ====================================
	// receivers: ack after a random delay, drop once req falls
	always @(posedge pclk) begin
		if (nbc_out_req && !nbc_out_ack && dly_n != 0) dly_n <= dly_n - 1;
		else if (nbc_out_req && !nbc_out_ack) begin
			nbc_out_ack <= 1'b1;
			dly_n <= $urandom % 4;
		end else if (!nbc_out_req) nbc_out_ack <= 1'b0;
	end
	always @(posedge pclk) begin
		if (peer_out_req && !peer_out_ack && dly_p != 0) dly_p <= dly_p - 1;
		else if (peer_out_req && !peer_out_ack) begin
			peer_out_ack <= 1'b1;
			dly_p <= $urandom % 4;
		end else if (!peer_out_req) peer_out_ack <= 1'b0;
	end
endmodule : sid_far_model
`default_nettype wire

// [sim/sid_switch_dma_assertions.sv]
// checker: timing relations on the top ports of the dma block.
// assumes bind into sid_switch_dma; async inputs are synced inside.
`timescale 1ns/1ps
`default_nettype none
module sid_dma_assertions (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// links
	input wire logic        nbc_in_req,
	input wire logic        nbc_in_ack,
	input wire logic        nbc_out_req,
	input wire logic        nbc_out_ack,
	input wire logic [15:0] nbc_data_out,
	input wire logic        nbc_data_oe_n,
	input wire logic        peer_in_req,
	input wire logic        peer_in_ack,
	input wire logic        peer_out_req,
	input wire logic [7:0]  peer_out_data,
	input wire logic        int_bus_err,
	// status
	input wire logic        sysctl_fail,
	input wire logic        nbc_fail,
	input wire logic        sys_init,
	input wire logic        led_top_red,
	input wire logic        led_mid,
	input wire logic        led_bot
);
	// ====================================
	// properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_wait_state:
	assert property (psel && !penable |=> !pready) else $error("pready without wait state");
	a_err_ready:
	assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
	a_cpu_waits:
	assert property (pready |-> !(nbc_in_ack | nbc_out_req | peer_in_ack | peer_out_req))
		else $error("cpu access during dma cycle");
	// an abort may drop ack early, so error time is excluded
	a_in_hold:
	assert property (nbc_in_ack && nbc_in_req && !int_bus_err |=> nbc_in_ack)
		else $error("inbound ack dropped early");
	a_peer_in_hold:
	assert property (peer_in_ack && peer_in_req |=> peer_in_ack) else $error("peer ack early");
	a_out_hold:
	assert property (nbc_out_req && !nbc_out_ack |=> nbc_out_req && $stable(nbc_data_out))
		else $error("outbound word not held");
	a_peer_out_hold:
	assert property (peer_out_req |=> peer_out_req || $past(peer_out_req, 2))
		else $error("peer request too short");
	a_oe_drive:
	assert property (nbc_out_req |-> !nbc_data_oe_n) else $error("word sent undriven");
	a_leds_dark:
	assert property ((!sysctl_fail && !nbc_fail && !sys_init) [*5] |-> !(led_top_red | led_mid | led_bot))
		else $error("led lit in normal run");
	a_init_all:
	assert property (sys_init [*5] |-> led_top_red && led_mid && led_bot) else $error("init leds");
	a_red_fail:
	assert property ((sysctl_fail || nbc_fail) [*5] |-> led_top_red) else $error("red led dark");
endmodule : sid_dma_assertions
bind sid_switch_dma sid_dma_assertions chk_u (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .nbc_in_req, .nbc_in_ack,
	.nbc_out_req, .nbc_out_ack, .nbc_data_out, .nbc_data_oe_n, .peer_in_req, .peer_in_ack,
	.peer_out_req,
	.peer_out_data, .int_bus_err, .sysctl_fail, .nbc_fail, .sys_init, .led_top_red, .led_mid,
	.led_bot
);
`default_nettype wire

// [sim/tb_top.sv]
// bench: path setup, alarm, dma runs, bus error and leds over apb.
// assumes sid_far_model answers both links.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import sid_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, iack = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata;
	logic        pready, pslverr, irq, int_bus_err = 0, o_prev = 0, p_prev = 0;
	logic        sysctl_fail = 0, nbc_fail = 0, sys_init = 0, led_top_red, led_mid, led_bot;
	logic [7:0]  irq_vector, peer_in_data, peer_out_data;
	logic [15:0] nbc_wire, far_d, nbc_data_out, path_setup0, path_setup1, alarm_out, v;
	logic [15:0] alarm_in = 0;
	logic        nbc_data_oe_n, nbc_in_req, nbc_in_ack, nbc_out_req, nbc_out_ack;
	logic        peer_in_req, peer_in_ack, peer_out_req, peer_out_ack;
	logic [32:0] exp_q[$], q;
	logic [15:0] out_q[$];
	logic [7:0]  b[4];
	int          fail_count = 0, check_count = 0, cyc = 0;
	always #25 pclk = ~pclk;
	// wire level of the shared word path
	assign nbc_wire = !nbc_data_oe_n ? nbc_data_out : far_d;
	sid_switch_dma dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .irq, .iack, .irq_vector, .nbc_data_in(nbc_wire), .nbc_data_out,
		.nbc_data_oe_n, .nbc_in_req, .nbc_in_ack, .nbc_out_req, .nbc_out_ack,
		.path_setup0, .path_setup1, .alarm_out, .alarm_in, .peer_in_data, .peer_in_req,
		.peer_in_ack, .peer_out_data, .peer_out_req, .peer_out_ack, .int_bus_err,
		.sysctl_fail, .nbc_fail, .sys_init, .led_top_red, .led_mid, .led_bot
	);
	sid_far_model far_u (
		.pclk, .nbc_drive(far_d), .nbc_in_req, .nbc_in_ack, .peer_in_data, .peer_in_req,
		.peer_in_ack, .nbc_out_req, .nbc_out_ack, .peer_out_req, .peer_out_ack
	);
	// ====================================
	// checking
	task automatic chk(input string nm, input logic [32:0] e, s);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic give_verdict;
		if (exp_q.size() + out_q.size() != 0) fail_count++;
		$display("checks %0d fails %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge pclk) if (++cyc == 30000) begin
		fail_count++;
		give_verdict();
	end
	// results are taken where settled, half a cycle before the edge
	always @(negedge pclk) begin
		if (psel && penable && pready) begin
			q = exp_q.pop_front();
			if (pwrite) q[31:0] = prdata;
			chk("apb", q, {pslverr, prdata});
		end
		if (nbc_out_req && !o_prev) chk("nbc_out", {17'h0, out_q.pop_front()}, {17'h0, nbc_data_out});
		if (peer_out_req && !p_prev) chk("peer_out", {17'h0, out_q.pop_front()}, {25'h0, peer_out_data});
		o_prev = nbc_out_req;
		p_prev = peer_out_req;
	end
	// ====================================
	// apb master and helpers
	task automatic apb(input logic w, input logic [31:0] a, d, input logic e);
		int n;
		n = 0;
		exp_q.push_back({e, d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(negedge pclk); while (pready !== 1'b1 && ++n < 300);
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next setup never reassigns psel in this step
		@(posedge pclk);
	endtask : apb
	task automatic start(input int ch, input logic [15:0] a, input logic [7:0] n);
		apb(1'b1, CH_STRIDE * 32'(ch) + OFS_ADDR, {16'h0, a}, 1'b0);
		apb(1'b1, CH_STRIDE * 32'(ch) + OFS_COUNT, {24'h0, n}, 1'b0);
		apb(1'b1, CH_STRIDE * 32'(ch) + OFS_CTRL, 32'h1, 1'b0);
	endtask : start
	task automatic stat(input int ch, input logic [31:0] s);
		apb(1'b0, CH_STRIDE * 32'(ch) + OFS_STAT, s, 1'b0);
		apb(1'b1, CH_STRIDE * 32'(ch) + OFS_STAT, s, 1'b0);
		apb(1'b0, CH_STRIDE * 32'(ch) + OFS_STAT, 32'h0, 1'b0);
	endtask : stat
	task automatic take_irq(input logic [7:0] vec, input logic use_vec);
		int n;
		n = 0;
		while (irq !== 1'b1 && n++ < 400) @(negedge pclk);
		chk("irq", 33'h1, {32'h0, irq});
		@(posedge pclk);
		iack <= 1'b1;
		repeat (6) @(posedge pclk);
		if (use_vec) chk("vector", {25'h0, vec}, {25'h0, irq_vector});
		iack <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("irq_clear", 33'h0, {32'h0, irq});
	endtask : take_irq
	// ====================================
	// main sequence
	initial begin
		void'($urandom(94500));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("leds", 33'h0, {30'h0, led_top_red, led_mid, led_bot});
		for (int i = 0; i < 2; i++) begin
			v = 16'($urandom);
			apb(1'b1, PATH0_ADDR + 32'(4 * i), {16'h0, v}, 1'b0);
			apb(1'b0, PATH0_ADDR + 32'(4 * i), {16'h0, v}, 1'b0);
			chk("path", {17'h0, v}, {17'h0, i ? path_setup1 : path_setup0});
		end
		v = 16'($urandom);
		alarm_in <= ~v;
		apb(1'b1, ALARM_ADDR, {16'h0, v}, 1'b0);
		apb(1'b0, ALARM_ADDR, {16'h0, ~v}, 1'b0);
		chk("alarm", {17'h0, v}, {17'h0, alarm_out});
		apb(1'b0, 32'h0000_0080, 32'h0, 1'b1);
		apb(1'b1, 32'h0000_0084, 32'h0000_1234, 1'b1);
		$display("test registers done");
		apb(1'b1, VEC_BASE, 32'h0000_E5A3, 1'b0);
		for (int c = 0; c < 4; c += 2) begin
			start(c, 16'h0100, 8'h02);
			apb(1'b0, CH_STRIDE * 32'(c) + OFS_STAT, 32'h1, 1'b0);
			for (int k = 0; k < 2; k++) begin
				v = 16'($urandom);
				{b[2 * k + 1], b[2 * k]} = v;
				far_u.send(c == 2, v);
			end
			take_irq(8'hA3, c == 0);
			stat(c, 32'h2);
			for (int k = 0; k < (c == 2 ? 2 : 4); k++)
				apb(1'b0, {SRAM_PAGE, 16'h0100 + 16'(k)}, {24'h0, c == 2 ? b[2 * k] : b[k]}, 1'b0);
		end
		$display("test inbound done");
		for (int c = 1; c < 4; c += 2) begin
			for (int k = 0; k < 4; k++) begin
				b[k] = 8'($urandom);
				apb(1'b1, {SRAM_PAGE, 16'h0200 + 16'(k)}, {24'h0, b[k]}, 1'b0);
			end
			for (int k = 0; k < 2; k++)
				out_q.push_back(c == 1 ? {b[2 * k + 1], b[2 * k]} : {8'h0, b[k]});
			start(c, 16'h0200, 8'h02);
			take_irq(8'h00, 1'b0);
			stat(c, 32'h2);
		end
		$display("test outbound done");
		int_bus_err <= 1'b1;
		start(0, 16'h0400, 8'h04);
		far_u.send(1'b0, 16'h5AC3);
		take_irq(8'hE5, 1'b1);
		int_bus_err <= 1'b0;
		stat(0, 32'h4);
		$display("test bus error done");
		for (int i = 0; i < 4; i++) begin
			{sysctl_fail, nbc_fail, sys_init} <= 3'b100 >> i;
			repeat (6) @(posedge pclk);
			chk("leds", i == 2 ? 33'h7 : (i == 3 ? 33'h0 : 33'h4), {30'h0, led_top_red, led_mid, led_bot});
		end
		$display("test leds done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire

// [verilog/sid_pkg.sv]
// switch interface dma: register map, field positions and engine states.
// assumes an APB master on pclk and a byte-wide on-card static RAM.
// Summary of operation
// - channels 0,1 move 16-bit words to bus controller
// - channels 2,3 move bytes to peer card
// - channels 0,2 inbound; channels 1,3 outbound
// - DMA touches only the 64 KB static RAM
// - card never masters the processor bus
// - operation ends after last word or byte
// - completion interrupts; ack returns normal vector
// - bus error ends cycle, aborts, flags, interrupts
// - error interrupt ack returns error vector
// - two path setup registers drive bus controller
// - path setup registers read back last value
// - processor access waits for current DMA cycle
// - static RAM on separate internal bus
// - bus controller link: 16-bit bidirectional, handshaken
// - two unidirectional byte channels to peer card
// - registers reach bus controller and alarm card
// - status LEDs dark in normal operation
// - top red LED on when controller fails
// - all LEDs on during system initialisation
package sid_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_CH      = 4;
	localparam int SRAM_AW     = 16;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [31:0] CH_STRIDE  = 32'h0000_0010;
	localparam logic [3:0]  OFS_ADDR   = 4'h0;
	localparam logic [3:0]  OFS_COUNT  = 4'h4;
	localparam logic [3:0]  OFS_CTRL   = 4'h8;
	localparam logic [3:0]  OFS_STAT   = 4'hC;
	localparam logic [31:0] VEC_BASE   = 32'h0000_0040;
	localparam logic [31:0] PATH0_ADDR = 32'h0000_0050;
	localparam logic [31:0] PATH1_ADDR = 32'h0000_0054;
	localparam logic [31:0] ALARM_ADDR = 32'h0000_0058;
	localparam logic [31:0] CARD_ADDR  = 32'h0000_005C;
	localparam logic [15:0] SRAM_PAGE  = 16'h0001;
	localparam logic [24:0] REG_PAGE   = 25'h000_0000;
	// ==========================================================
	// fields
	localparam int CTRL_START = 0;
	localparam int STAT_ACT   = 0;
	localparam int STAT_DONE  = 1;
	localparam int STAT_ERR   = 2;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	// ==========================================================
	// engine
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_IN_ACK,
		ST_OUT_REQ,
		ST_OUT_REL
	} sid_state_type;
endpackage : sid_pkg

// [verilog/sid_switch_dma.sv]
// switch interface card: four-channel DMA to and from on-card RAM, path setup,
// alarm window, interrupt vectors and status LEDs behind an APB slave.
// assumes link, failure and ack pins are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module sid_switch_dma
	import sid_pkg::*;
#(
	parameter int SRAM_DEPTH = 65536
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// processor interrupt
	output logic             irq,
	input  wire logic        iack,
	output logic [7:0]       irq_vector,
	// network bus controller data path
	input  wire logic [15:0] nbc_data_in,
	output logic [15:0]      nbc_data_out,
	output logic             nbc_data_oe_n,
	input  wire logic        nbc_in_req,
	output logic             nbc_in_ack,
	output logic             nbc_out_req,
	input  wire logic        nbc_out_ack,
	// path setup and alarm card
	output logic [15:0]      path_setup0,
	output logic [15:0]      path_setup1,
	output logic [15:0]      alarm_out,
	input  wire logic [15:0] alarm_in,
	// peer card byte channels
	input  wire logic [7:0]  peer_in_data,
	input  wire logic        peer_in_req,
	output logic             peer_in_ack,
	output logic [7:0]       peer_out_data,
	output logic             peer_out_req,
	input  wire logic        peer_out_ack,
	// internal bus error and card status
	input  wire logic        int_bus_err,
	input  wire logic        sysctl_fail,
	input  wire logic        nbc_fail,
	input  wire logic        sys_init,
	output logic             led_top_red,
	output logic             led_mid,
	output logic             led_bot
);
	// ==========================================================
	// synchronisers
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] sync_meta;
	logic [NSYNC-1:0] sync_q;
	wire  [NSYNC-1:0] sync_raw = {iack, sys_init, nbc_fail, sysctl_fail, int_bus_err,
		peer_out_ack, peer_in_req, nbc_out_ack, nbc_in_req};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_meta <= '0;
			sync_q    <= '0;
		end else begin
			sync_meta <= sync_raw;
			sync_q    <= sync_meta;
		end
	end
	wire nbc_in_req_s  = sync_q[0];
	wire nbc_out_ack_s = sync_q[1];
	wire peer_in_req_s = sync_q[2];
	wire peer_out_ack_s = sync_q[3];
	wire berr_s        = sync_q[4];
	wire sysctl_fail_s = sync_q[5];
	wire nbc_fail_s    = sync_q[6];
	wire sys_init_s    = sync_q[7];
	wire iack_s        = sync_q[8];

	// ==========================================================
	// state
	logic [7:0]  sram [SRAM_DEPTH];
	logic [15:0] ch_addr [NUM_CH];
	logic [15:0] ch_cnt [NUM_CH];
	logic [15:0] ch_vec [NUM_CH];
	logic [NUM_CH-1:0] ch_act;
	logic [NUM_CH-1:0] ch_done;
	logic [NUM_CH-1:0] ch_err;
	logic [NUM_CH-1:0] ip;
	logic [NUM_CH-1:0] ip_err;
	sid_state_type state;
	logic [1:0]  cur;
	logic        apb_loaded;
	logic        iack_prev;

	// ==========================================================
	// apb decode
	wire access     = psel & penable;
	wire done_xfer  = access & pready;
	wire wr_now     = done_xfer & pwrite;
	wire sram_hit   = (paddr[31:16] == SRAM_PAGE);
	wire reg_page   = (paddr[31:7] == REG_PAGE) && (paddr[1:0] == 2'b00);
	wire ch_hit     = reg_page && (paddr[6] == 1'b0);
	wire [1:0] rch  = paddr[5:4];
	wire [3:0] rofs = paddr[3:0];
	wire vec_hit    = reg_page && (paddr[6:4] == VEC_BASE[6:4]);
	wire path0_hit  = reg_page && (paddr[6:0] == PATH0_ADDR[6:0]);
	wire path1_hit  = reg_page && (paddr[6:0] == PATH1_ADDR[6:0]);
	wire alarm_hit  = reg_page && (paddr[6:0] == ALARM_ADDR[6:0]);
	wire card_hit   = reg_page && (paddr[6:0] == CARD_ADDR[6:0]);
	wire mapped     = sram_hit | ch_hit | vec_hit | path0_hit | path1_hit |
		alarm_hit | card_hit;
	wire [SRAM_AW-1:0] cpu_sram_a = paddr[SRAM_AW-1:0];
	wire eng_idle   = (state == ST_IDLE);

	// ==========================================================
	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sram_hit)
			rd_mux = {24'h00_0000, sram[cpu_sram_a]};
		else if (ch_hit) begin
			case (rofs)
				OFS_ADDR:  rd_mux = {16'h0000, ch_addr[rch]};
				OFS_COUNT: rd_mux = {16'h0000, ch_cnt[rch]};
				OFS_STAT:  rd_mux = {29'h0000_0000, ch_err[rch], ch_done[rch], ch_act[rch]};
				default:   rd_mux = 32'h0000_0000;
			endcase
		end else if (vec_hit)
			rd_mux = {16'h0000, ch_vec[rch]};
		else if (path0_hit)
			rd_mux = {16'h0000, path_setup0};
		else if (path1_hit)
			rd_mux = {16'h0000, path_setup1};
		else if (alarm_hit)
			rd_mux = {16'h0000, alarm_in};
		else if (card_hit)
			rd_mux = {28'h000_0000, sys_init_s, nbc_fail_s, sysctl_fail_s, berr_s};
	end

	// ==========================================================
	// apb answer: data latched only while the engine sits idle, and the
	// engine never starts a cycle while psel is high, so the access
	// completes after any cycle in progress and before the next one
	assign pready  = access & apb_loaded;
	assign pslverr = pready & ~mapped;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_loaded <= 1'b0;
			prdata     <= 32'h0000_0000;
		end else if (done_xfer) begin
			apb_loaded <= 1'b0;
		end else if (access && eng_idle && !apb_loaded) begin
			apb_loaded <= 1'b1;
			prdata     <= rd_mux;
		end
	end

	// ==========================================================
	// channel request and priority
	// even channels inbound, odd outbound; 0,1 bus controller, 2,3 peer
	logic [NUM_CH-1:0] ch_ready;
	assign ch_ready[0] = ch_act[0] & nbc_in_req_s;
	assign ch_ready[1] = ch_act[1] & ~nbc_out_ack_s;
	assign ch_ready[2] = ch_act[2] & peer_in_req_s;
	assign ch_ready[3] = ch_act[3] & ~peer_out_ack_s;

	logic [1:0] pick;
	always_comb begin
		pick = 2'd0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (ch_ready[i])
				pick = i[1:0];
		end
	end
	wire start_cyc = eng_idle & ~psel & (|ch_ready);
	wire pick_wide = (pick[1] == 1'b0);
	wire [15:0] pick_addr = ch_addr[pick];
	wire [SRAM_AW-1:0] sa0 = pick_addr[SRAM_AW-1:0];
	wire [SRAM_AW-1:0] sa1 = sa0 + 1'b1;

	// ==========================================================
	// engine events
	wire cur_wide = (cur[1] == 1'b0);
	wire in_fin   = (state == ST_IN_ACK) &&
		!(cur_wide ? nbc_in_req_s : peer_in_req_s);
	wire out_fin  = (state == ST_OUT_REQ) &&
		(cur_wide ? nbc_out_ack_s : peer_out_ack_s);
	wire abort    = !eng_idle && berr_s;
	wire advance  = (in_fin | out_fin) & ~abort;
	wire last     = (ch_cnt[cur] == 16'h0001);
	wire [15:0] step = cur_wide ? 16'h0002 : 16'h0001;

	// ==========================================================
	// engine sequencer: four-phase handshake per word or byte
	sid_state_type next_state;
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:    if (start_cyc) next_state = pick[0] ? ST_OUT_REQ : ST_IN_ACK;
			ST_IN_ACK:  if (abort || in_fin) next_state = ST_IDLE;
			ST_OUT_REQ: begin
				if (abort)
					next_state = ST_IDLE;
				else if (out_fin)
					next_state = ST_OUT_REL;
			end
			ST_OUT_REL: if (abort || !(cur_wide ? nbc_out_ack_s : peer_out_ack_s))
				next_state = ST_IDLE;
			default:    next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			cur   <= 2'd0;
		end else begin
			state <= next_state;
			if (start_cyc)
				cur <= pick;
		end
	end

	// ==========================================================
	// link drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nbc_in_ack    <= 1'b0;
			peer_in_ack   <= 1'b0;
			nbc_out_req   <= 1'b0;
			peer_out_req  <= 1'b0;
			nbc_data_out  <= 16'h0000;
			nbc_data_oe_n <= 1'b1;
			peer_out_data <= 8'h00;
		end else begin
			if (start_cyc && pick == 2'd0)
				nbc_in_ack <= 1'b1;
			else if (nbc_in_ack && (abort || in_fin))
				nbc_in_ack <= 1'b0;
			if (start_cyc && pick == 2'd2)
				peer_in_ack <= 1'b1;
			else if (peer_in_ack && (abort || in_fin))
				peer_in_ack <= 1'b0;
			if (start_cyc && pick == 2'd1) begin
				nbc_data_out  <= {sram[sa1], sram[sa0]};
				nbc_data_oe_n <= 1'b0;
				nbc_out_req   <= 1'b1;
			end else if (nbc_out_req && (abort || out_fin)) begin
				nbc_out_req <= 1'b0;
			end else if (!nbc_out_req && state != ST_OUT_REL) begin
				nbc_data_oe_n <= 1'b1;
			end
			if (start_cyc && pick == 2'd3) begin
				peer_out_data <= sram[sa0];
				peer_out_req  <= 1'b1;
			end else if (peer_out_req && (abort || out_fin)) begin
				peer_out_req <= 1'b0;
			end
		end
	end

	// ==========================================================
	// static ram: internal bus only, written by inbound DMA or cpu
	// no reset: contents are data, not control
	wire cpu_sram_wr = wr_now & sram_hit;
	always_ff @(posedge pclk) begin
		if (start_cyc && pick == 2'd0) begin
			sram[sa0] <= nbc_data_in[7:0];
			sram[sa1] <= nbc_data_in[15:8];
		end else if (start_cyc && pick == 2'd2) begin
			sram[sa0] <= peer_in_data;
		end else if (cpu_sram_wr) begin
			sram[cpu_sram_a] <= pwdata[7:0];
		end
	end

	// ==========================================================
	// channel registers
	wire ch_wr = wr_now & ch_hit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ch_addr[i] <= 16'h0000;
				ch_cnt[i]  <= 16'h0000;
				ch_vec[i]  <= VEC_RESET;
			end
			ch_act  <= '0;
			ch_done <= '0;
			ch_err  <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (ch_wr && rch == i[1:0] && rofs == OFS_ADDR && !ch_act[i])
					ch_addr[i] <= pwdata[15:0];
				else if (advance && cur == i[1:0])
					ch_addr[i] <= ch_addr[i] + step;
				if (ch_wr && rch == i[1:0] && rofs == OFS_COUNT && !ch_act[i])
					ch_cnt[i] <= pwdata[15:0];
				else if (advance && cur == i[1:0])
					ch_cnt[i] <= ch_cnt[i] - 16'h0001;
				if (wr_now && vec_hit && rch == i[1:0])
					ch_vec[i] <= pwdata[15:0];
				if (abort && cur == i[1:0])
					ch_act[i] <= 1'b0;
				else if (advance && cur == i[1:0] && last)
					ch_act[i] <= 1'b0;
				else if (ch_wr && rch == i[1:0] && rofs == OFS_CTRL &&
					pwdata[CTRL_START] && ch_cnt[i] != 16'h0000)
					ch_act[i] <= 1'b1;
				// event set wins over a write-one clear in the same cycle
				ch_done[i] <= (advance && cur == i[1:0] && last) ||
					(ch_done[i] && !(ch_wr && rch == i[1:0] && rofs == OFS_STAT &&
					pwdata[STAT_DONE]));
				ch_err[i] <= (abort && cur == i[1:0]) ||
					(ch_err[i] && !(ch_wr && rch == i[1:0] && rofs == OFS_STAT &&
					pwdata[STAT_ERR]));
			end
		end
	end

	// ==========================================================
	// interrupt and vector: lowest pending channel served per ack
	logic [1:0] ack_ch;
	always_comb begin
		ack_ch = 2'd0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (ip[i])
				ack_ch = i[1:0];
		end
	end
	wire ack_edge = iack_s & ~iack_prev & (|ip);
	wire [15:0] ack_vec = ch_vec[ack_ch];
	assign irq = |ip;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ip         <= '0;
			ip_err     <= '0;
			iack_prev  <= 1'b0;
			irq_vector <= 8'h00;
		end else begin
			iack_prev <= iack_s;
			if (ack_edge)
				irq_vector <= ip_err[ack_ch] ? ack_vec[15:8] : ack_vec[7:0];
			for (int i = 0; i < NUM_CH; i++) begin
				if (abort && cur == i[1:0]) begin
					ip[i]     <= 1'b1;
					ip_err[i] <= 1'b1;
				end else if (advance && cur == i[1:0] && last) begin
					ip[i]     <= 1'b1;
					ip_err[i] <= 1'b0;
				end else if (ack_edge && ack_ch == i[1:0]) begin
					ip[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// path setup, alarm window and status LEDs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path_setup0 <= 16'h0000;
			path_setup1 <= 16'h0000;
			alarm_out   <= 16'h0000;
			led_top_red <= 1'b0;
			led_mid     <= 1'b0;
			led_bot     <= 1'b0;
		end else begin
			if (wr_now && path0_hit)
				path_setup0 <= pwdata[15:0];
			if (wr_now && path1_hit)
				path_setup1 <= pwdata[15:0];
			if (wr_now && alarm_hit)
				alarm_out <= pwdata[15:0];
			led_top_red <= sys_init_s | sysctl_fail_s | nbc_fail_s;
			led_mid     <= sys_init_s;
			led_bot     <= sys_init_s;
		end
	end
endmodule : sid_switch_dma
`default_nettype wire
